// *** pkg/cdh_pkg.sv ***
/*
 * Constants and types of the character display host port: timing, command field
 * positions, reset values, memory sizes and the cascade shift register length.
 * Assumes a single 10 MHz system clock.
 */
package cdh_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int OP_TIME_NS = 40000;
	// Least time, so round up to whole cycles
	localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CASC_HALF_CYCLES = 4;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int DISP_DEPTH = 128;
	localparam int GLYPH_DEPTH = 64;
	localparam int CASC_STAGES = 100;
	localparam int FIFO_DEPTH = 32;
	localparam int DATA_W = 8;
	localparam int PTR_W = 7;

	// ----------------------------------------------------------------
	// Host register select and status layout
	// ----------------------------------------------------------------
	localparam logic SEL_COMMAND = 1'b0;
	localparam logic SEL_DATA = 1'b1;
	localparam int STATUS_BUSY_BIT = 7;

	// ----------------------------------------------------------------
	// Command field positions
	// ----------------------------------------------------------------
	localparam int CMD_DISP_ADDR_BIT = 7;
	localparam int CMD_GLYPH_ADDR_BIT = 6;
	localparam int CMD_FUNC_BIT = 5;
	localparam int CMD_SHIFT_BIT = 4;
	localparam int CMD_ENTRY_BIT = 2;
	localparam int FUNC_LINES_BIT = 3;
	localparam int SHIFT_DISPLAY_BIT = 3;
	localparam int SHIFT_RIGHT_BIT = 2;
	localparam int ENTRY_INC_BIT = 1;

	// ----------------------------------------------------------------
	// Reset values and fixed addresses
	// ----------------------------------------------------------------
	localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;
	localparam logic [PTR_W-1:0] BASE_RESET = 7'h00;
	localparam logic INC_RESET = 1'b1;
	localparam logic TWO_LINE_RESET = 1'b0;
	localparam logic [PTR_W-1:0] CASC_START_ADDR = 7'h28;

	// Host access as captured from the pins
	typedef struct packed {
		logic rs;
		logic rw;
		logic [DATA_W-1:0] data;
	} cdh_host_req_s;

	typedef enum {ENG_IDLE, ENG_BUSY} cdh_eng_e;
endpackage : cdh_pkg

// *** hdl/cdh_host_port.sv ***
/*
 * Character display host port: command and data holding registers, busy and
 * address pointer, display and glyph memories, display shift, a data write FIFO
 * and the master/slave cascade shift register.
 * Assumes host pins are asynchronous to clk_sys and held stable around the strobe.
 */
//
// Operation
// - reg_select low picks command register, high picks data register.
// - Status read returns busy on bit 7 and pointer on bits 6..0.
// - Command write captures the byte and starts its internal operation.
// - Data write latches byte and stores it at pointer in chosen memory.
// - Data read loads holding register from memory at pointer and presents it.
// - Command register is write only; no read path returns it.
// - Command and data holding registers are eight bits wide.
// - While busy, report busy high and ignore commands.
// - When idle or done, busy reads low and next command is accepted.
// - Address command loads pointer and selects display or glyph memory.
// - Each data write or read steps pointer by one in chosen direction.
// - Display memory holds 128 eight-bit character codes.
// - Pointer is seven-bit binary, bit 6 most significant.
// - One-line mode maps positions 1..128 to addresses 00..7F.
// - Two-line mode: line one uses 00..3F, line two 40..7F.
// - Display shift moves window by one, wrapping within each line range.
// - Master cascades a slave to show 40 characters per line.
// - Role pin high drives cascade pins out; low takes them in.
// - Cascade shift register advances on falling shift clock edge.
// - Direction high moves data stage 100 to 1; low, 1 to 100.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Synchronous FIFO
// ----------------------------------------------------------------
module cdh_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_sys, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic in_valid, // Word offered
	output logic in_ready, // Room for a word
	input wire logic [WIDTH-1:0] in_data, // Word in
	output logic out_valid, // Word available
	input wire logic out_ready, // Drain takes word
	output logic [WIDTH-1:0] out_data // Oldest word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	// Honest flags straight from the occupancy count
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rd_r];
	// Storage has no reset; only the pointers matter
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end
	// Pointer and count update
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= push ? AW'(wr_r + 1'b1) : wr_r;
			rd_r <= pop ? AW'(rd_r + 1'b1) : rd_r;
			cnt_r <= (AW+1)'(cnt_r + push - pop);
		end
	end
endmodule : cdh_fifo
// ----------------------------------------------------------------
// Host port top
// ----------------------------------------------------------------
module cdh_host_port
	import cdh_pkg::*;
#(
	parameter int OP_CNT = OP_CYCLES,
	parameter int HALF_CNT = CASC_HALF_CYCLES
) (
	input wire logic clk_sys, // System clock, 10 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic bus_strobe, // Host enable pin, access ends on fall
	input wire logic reg_select, // Host register select pin
	input wire logic read_not_write, // Host direction pin, high reads
	input wire logic [DATA_W-1:0] db_in, // Host data bus in
	output logic [DATA_W-1:0] db_out, // Host data bus out
	output logic db_oe, // Host data bus drive enable
	input wire logic role_master, // Role pin, high is master
	input wire logic shift_direction, // Cascade shift direction pin
	input wire logic casc_data_in, // Cascade serial data in
	output logic casc_data_out, // Cascade serial data out
	input wire logic casc_clk_in, // Cascade shift clock in
	output logic cascade_shift_clock, // Cascade shift clock out
	input wire logic casc_latch_in, // Cascade latch in
	output logic cascade_latch, // Cascade latch out
	output logic casc_oe, // Cascade pins drive enable
	input wire logic scan_line, // Scan line select, same clock
	input wire logic [PTR_W-1:0] scan_col, // Scan column, same clock
	output logic [DATA_W-1:0] scan_char, // Character at scanned position
	output logic [CASC_STAGES-1:0] casc_columns // Latched cascade stages
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int SW = 16;
	logic [SW-1:0] s1_r;
	logic [SW-1:0] s2_r;
	logic e_d3_r;
	logic cclk_d3_r;
	logic clat_d3_r;
	wire [SW-1:0] pins = {bus_strobe, reg_select, read_not_write, db_in, role_master,
		shift_direction, casc_data_in, casc_clk_in, casc_latch_in};

	// Two flops for every pin; edge detectors look only at stage two onward
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s1_r <= '0;
			s2_r <= '0;
			e_d3_r <= 1'b0;
			cclk_d3_r <= 1'b0;
			clat_d3_r <= 1'b0;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
			e_d3_r <= s2_r[15];
			cclk_d3_r <= s2_r[1];
			clat_d3_r <= s2_r[0];
		end
	end
	cdh_host_req_s req;
	wire e_s2 = s2_r[15];
	wire is_master = s2_r[4];
	wire shl_s2 = s2_r[3];
	wire cdata_s2 = s2_r[2];
	assign req = s2_r[14:5];
	wire strobe_fall = e_d3_r & ~e_s2;
	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	cdh_eng_e eng_r;
	logic [15:0] op_cnt_r;
	logic [DATA_W-1:0] command_holding_reg;
	logic [DATA_W-1:0] data_holding_reg;
	logic [PTR_W-1:0] addr_pointer;
	logic glyph_sel_r;
	logic inc_r;
	logic two_line_r;
	logic [PTR_W-1:0] base_r;
	logic [DATA_W-1:0] db_out_r;
	logic [DATA_W-1:0] scan_char_r;
	logic [DATA_W-1:0] display_char_memory [DISP_DEPTH];
	logic [DATA_W-1:0] glyph_pattern_memory [GLYPH_DEPTH];
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data;
	// Pointer step, modulo 128 either way
	function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p, input logic up);
		step_ptr = up ? PTR_W'(p + 1'b1) : PTR_W'(p - 1'b1);
	endfunction : step_ptr
	// Window base shift, wrapping within a line's range
	function automatic logic [PTR_W-1:0] shift_base(input logic [PTR_W-1:0] b,
		input logic right, input logic two);
		logic [PTR_W-1:0] n;
		n = right ? PTR_W'(b - 1'b1) : PTR_W'(b + 1'b1);
		shift_base = two ? {1'b0, n[PTR_W-2:0]} : n;
	endfunction : shift_base
	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	// Pending FIFO words count as busy so commands and reads keep write order
	wire busy_indicator = (eng_r == ENG_BUSY) | fifo_out_valid;
	wire acc_cmd = strobe_fall & (req.rs == SEL_COMMAND) & ~req.rw;
	wire acc_wr = strobe_fall & (req.rs == SEL_DATA) & ~req.rw;
	wire acc_rd = strobe_fall & (req.rs == SEL_DATA) & req.rw;
	wire cmd_take = acc_cmd & ~busy_indicator;
	wire rd_take = acc_rd & ~busy_indicator;
	wire drain = fifo_out_valid & (eng_r == ENG_IDLE);
	wire [DATA_W-1:0] cmd = req.data;
	wire c_disp = cmd[CMD_DISP_ADDR_BIT];
	wire c_glyph = ~c_disp & cmd[CMD_GLYPH_ADDR_BIT];
	wire c_func = ~c_disp & ~c_glyph & cmd[CMD_FUNC_BIT];
	wire c_shift = (cmd[7:5] == 3'h0) & cmd[CMD_SHIFT_BIT];
	wire c_entry = (cmd[7:3] == 5'h00) & cmd[CMD_ENTRY_BIT];
	wire [DATA_W-1:0] disp_rd = display_char_memory[addr_pointer];
	wire [DATA_W-1:0] glyph_rd = glyph_pattern_memory[addr_pointer[PTR_W-2:0]];
	wire [DATA_W-1:0] mem_rd = glyph_sel_r ? glyph_rd : disp_rd;
	// Status word never exposes the command register
	wire [DATA_W-1:0] status_word = {busy_indicator, addr_pointer};
	// ----------------------------------------------------------------
	// Data write FIFO; a write arriving while full is dropped
	// ----------------------------------------------------------------
	cdh_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clk_sys(clk_sys),
		.srst(srst),
		.in_valid(acc_wr),
		.in_ready(fifo_in_ready),
		.in_data(req.data),
		.out_valid(fifo_out_valid),
		.out_ready(drain),
		.out_data(fifo_out_data)
	);
	// ----------------------------------------------------------------
	// Internal operation engine
	// ----------------------------------------------------------------
	// Every command and every drained data word occupies the engine for OP_CNT cycles
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			eng_r <= ENG_IDLE;
			op_cnt_r <= '0;
		end else begin
			case (eng_r)
				ENG_IDLE: begin
					if (cmd_take | drain) begin
						eng_r <= ENG_BUSY;
						op_cnt_r <= 16'(OP_CNT - 1);
					end
				end
				ENG_BUSY: begin
					op_cnt_r <= 16'(op_cnt_r - 1'b1);
					if (op_cnt_r == 16'h0000) begin
						eng_r <= ENG_IDLE;
					end
				end
				default: eng_r <= ENG_IDLE;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Holding registers, pointer and mode bits
	// ----------------------------------------------------------------
	wire [PTR_W-1:0] ptr_nxt = (cmd_take & c_disp) ? cmd[PTR_W-1:0] :
		(cmd_take & c_glyph) ? {1'b0, cmd[PTR_W-2:0]} :
		(drain | rd_take) ? step_ptr(addr_pointer, inc_r) : addr_pointer;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			command_holding_reg <= '0;
			data_holding_reg <= '0;
			addr_pointer <= PTR_RESET;
			glyph_sel_r <= 1'b0;
			inc_r <= INC_RESET;
			two_line_r <= TWO_LINE_RESET;
			base_r <= BASE_RESET;
		end else begin
			command_holding_reg <= cmd_take ? cmd : command_holding_reg;
			data_holding_reg <= drain ? fifo_out_data :
				rd_take ? mem_rd : data_holding_reg;
			addr_pointer <= ptr_nxt;
			glyph_sel_r <= (cmd_take & (c_disp | c_glyph)) ? c_glyph : glyph_sel_r;
			inc_r <= (cmd_take & c_entry) ? cmd[ENTRY_INC_BIT] : inc_r;
			two_line_r <= (cmd_take & c_func) ? cmd[FUNC_LINES_BIT] : two_line_r;
			base_r <= (cmd_take & c_shift & cmd[SHIFT_DISPLAY_BIT]) ?
				shift_base(base_r, cmd[SHIFT_RIGHT_BIT], two_line_r) : base_r;
		end
	end
	// Memory write at the pointer in the chosen memory
	always_ff @(posedge clk_sys) begin
		if (drain & ~glyph_sel_r) begin
			display_char_memory[addr_pointer] <= fifo_out_data;
		end
		if (drain & glyph_sel_r) begin
			glyph_pattern_memory[addr_pointer[PTR_W-2:0]] <= fifo_out_data;
		end
	end
	// ----------------------------------------------------------------
	// Host read path and display scan
	// ----------------------------------------------------------------
	wire [PTR_W-1:0] col_sum = PTR_W'(scan_col + base_r);
	// One line spans all 128; two lines each wrap inside their 64
	wire [PTR_W-1:0] scan_addr = two_line_r ? {scan_line, col_sum[PTR_W-2:0]}
		: col_sum;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			db_out_r <= '0;
			scan_char_r <= '0;
		end else begin
			db_out_r <= (req.rs == SEL_DATA) ? mem_rd : status_word;
			scan_char_r <= display_char_memory[scan_addr];
		end
	end
	assign db_out = db_out_r;
	assign db_oe = e_s2 & req.rw;
	assign scan_char = scan_char_r;
	// ----------------------------------------------------------------
	// Cascade serial path
	// ----------------------------------------------------------------
	logic [7:0] div_r;
	logic mclk_r;
	logic mlat_r;
	logic [6:0] stage_cnt_r;
	logic [2:0] bit_r;
	logic [PTR_W-1:0] casc_addr_r;
	logic [CASC_STAGES-1:0] stage_r;
	logic [CASC_STAGES-1:0] columns_r;
	logic casc_dout_r;
	wire tick = (div_r == 8'(HALF_CNT - 1));
	wire m_fall = is_master & tick & mclk_r;
	wire shift_fall = is_master ? m_fall : (cclk_d3_r & ~s2_r[1]);
	wire latch_rise = is_master ? (m_fall & (stage_cnt_r == 7'(CASC_STAGES - 1)))
		: (s2_r[0] & ~clat_d3_r);
	// Master feeds the slave the characters beyond its own 40
	wire [DATA_W-1:0] casc_char = display_char_memory[casc_addr_r];
	wire ser_in = is_master ? casc_char[3'h7 - bit_r] : cdata_s2;
	wire [CASC_STAGES-1:0] stage_nxt = shl_s2 ? {ser_in, stage_r[CASC_STAGES-1:1]}
		: {stage_r[CASC_STAGES-2:0], ser_in};
	wire ser_out = shl_s2 ? stage_r[0] : stage_r[CASC_STAGES-1];
	// Master clock divider and frame counters; idle as slave
	always_ff @(posedge clk_sys) begin
		if (srst | ~is_master) begin
			div_r <= '0;
			mclk_r <= 1'b0;
			mlat_r <= 1'b0;
			stage_cnt_r <= '0;
			bit_r <= '0;
			casc_addr_r <= CASC_START_ADDR;
		end else begin
			div_r <= tick ? 8'h00 : 8'(div_r + 1'b1);
			mclk_r <= tick ? ~mclk_r : mclk_r;
			mlat_r <= latch_rise ? 1'b1 : (tick ? 1'b0 : mlat_r);
			stage_cnt_r <= latch_rise ? 7'h00 : (m_fall ? 7'(stage_cnt_r + 1'b1) : stage_cnt_r);
			bit_r <= m_fall ? 3'(bit_r + 1'b1) : bit_r;
			casc_addr_r <= (m_fall & (bit_r == 3'h7)) ? step_ptr(casc_addr_r, 1'b1) : casc_addr_r;
		end
	end

	// Shift register, latch and serial output
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stage_r <= '0;
			columns_r <= '0;
			casc_dout_r <= 1'b0;
		end else begin
			stage_r <= shift_fall ? stage_nxt : stage_r;
			columns_r <= latch_rise ? stage_r : columns_r;
			casc_dout_r <= ser_out;
		end
	end

	assign casc_oe = is_master;
	assign casc_data_out = casc_dout_r;
	assign cascade_shift_clock = mclk_r;
	assign cascade_latch = mlat_r;
	assign casc_columns = columns_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Tracks the engine's actual length so a shortened engine is still bounded tightly
	localparam int AST_BUSY_MAX = OP_CNT + 2;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	AST_ADDR_LOAD: assert property (cmd_take && c_disp |=>
		addr_pointer == $past(cmd[PTR_W-1:0]) && !glyph_sel_r)
		else $error("pointer not loaded by address command");
	AST_BUSY_HOLD: assert property (cmd_take |=> busy_indicator [*8])
		else $error("busy dropped early after command");
	AST_BUSY_CLEAR: assert property (cmd_take && !fifo_out_valid && !acc_wr |->
		##[1:AST_BUSY_MAX] !busy_indicator)
		else $error("busy never cleared after command");
	AST_CMD_IGNORED: assert property (acc_cmd && busy_indicator |=>
		$stable(two_line_r) && $stable(inc_r) && $stable(base_r))
		else $error("command accepted while busy");
	AST_PTR_STEP: assert property (drain |=>
		addr_pointer == step_ptr($past(addr_pointer), $past(inc_r)))
		else $error("pointer did not step after data write");
	AST_STATUS_READ: assert property (req.rs == SEL_COMMAND |=>
		db_out == {$past(busy_indicator), $past(addr_pointer)})
		else $error("status word wrong");
	AST_WRAP_TWO: assert property (cmd_take && c_shift && cmd[SHIFT_DISPLAY_BIT] &&
		cmd[SHIFT_RIGHT_BIT] && two_line_r && base_r == 7'h00 |=> base_r == 7'h3F)
		else $error("two-line shift did not wrap to 3F");
	AST_CASC_SHIFT: assert property (shift_fall && shl_s2 |=>
		stage_r[CASC_STAGES-1] == $past(ser_in) && stage_r[0] == $past(stage_r[1]))
		else $error("cascade shift wrong");
	AST_SLAVE_QUIET: assert property (!casc_oe |-> !cascade_latch && !cascade_shift_clock)
		else $error("slave drives cascade outputs");

	COV_CMD: cover property (cmd_take ##1 busy_indicator [*3] ##[1:AST_BUSY_MAX] !busy_indicator);
	COV_FIFO_FULL: cover property (!fifo_in_ready);
	COV_READ: cover property (rd_take);
	COV_LATCH: cover property (is_master && latch_rise);
endmodule : cdh_host_port

// *** testbench/cdh_host_model.sv ***
/*
 * Host processor model for the character display host port.
 * Assumes the bench calls access() right after a clk_sys edge.
 */
`timescale 1ns/1ps
module cdh_host_model
	import cdh_pkg::*;
(
	input wire logic clk_sys, // System clock
	output logic bus_strobe, // Enable pin
	output logic reg_select, // Register select pin
	output logic read_not_write, // Direction pin
	output logic [DATA_W-1:0] db_in, // Bus as seen by the device
	input wire logic [DATA_W-1:0] db_out, // Device bus value
	input wire logic db_oe, // Device drives the bus
	output logic rd_valid, // Read result pulse
	output logic [DATA_W-1:0] rd_data // Read result
);
	// Pins idle with the strobe low
	initial begin
		bus_strobe = 1'b0;
		reg_select = 1'b0;
		read_not_write = 1'b1;
		db_in = 8'h5A;
		rd_valid = 1'b0;
		rd_data = 8'h00;
	end

	// One bus cycle; data is set up 7 clocks before the strobe falls.
	// A released bus shows the inverse byte so a stale copy cannot pass.
	task automatic access(input logic rs, input logic rw, input logic [7:0] d,
			input logic rep, output logic [7:0] q);
		@(posedge clk_sys);
		#1;
		reg_select = rs;
		read_not_write = rw;
		db_in = rw ? ~d : d;
		bus_strobe = 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		q = db_oe ? db_out : 8'hXX;
		rd_valid = rep;
		rd_data = q;
		@(posedge clk_sys);
		#1;
		rd_valid = 1'b0;
		bus_strobe = 1'b0;
		repeat (5) @(posedge clk_sys);
		#1;
		db_in = ~d;
	endtask : access
endmodule : cdh_host_model

// *** testbench/cdh_host_port_tb_top.sv ***
/*
 * Self-checking bench for the character display host port.
 * Assumes cdh_pkg and the host model are compiled first.
 */
`timescale 1ns/1ps
module cdh_host_port_tb_top
	import cdh_pkg::*;
;
	localparam int OP_T = 40;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic role_master = 1'b0;
	logic shift_direction = 1'b0;
	logic casc_data_in = 1'b0;
	logic casc_clk_in = 1'b0;
	logic casc_latch_in = 1'b0;
	logic scan_line = 1'b0;
	logic [PTR_W-1:0] scan_col = 7'h00;
	logic bus_strobe, reg_select, read_not_write, db_oe, host_rv, scan_v;
	logic casc_oe, cascade_shift_clock, seen, casc_dout, casc_lat, lat_seen;
	logic [7:0] db_in, db_out, host_rd, scan_char, scan_cap;
	logic [CASC_STAGES-1:0] casc_columns, v;
	logic [7:0] d [5];
	logic [7:0] exp_q [$];
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int seed = 32'hE964;

	always #50 clk_sys = ~clk_sys;

	cdh_host_port #(.OP_CNT(OP_T), .HALF_CNT(2)) dut (.clk_sys(clk_sys), .srst(srst),
		.bus_strobe(bus_strobe), .reg_select(reg_select), .read_not_write(read_not_write),
		.db_in(db_in), .db_out(db_out), .db_oe(db_oe), .role_master(role_master),
		.shift_direction(shift_direction), .casc_data_in(casc_data_in),
		.casc_data_out(casc_dout), .casc_clk_in(casc_clk_in),
		.cascade_shift_clock(cascade_shift_clock), .casc_latch_in(casc_latch_in),
		.cascade_latch(casc_lat), .casc_oe(casc_oe), .scan_line(scan_line), .scan_col(scan_col),
		.scan_char(scan_char), .casc_columns(casc_columns));

	cdh_host_model host (.clk_sys(clk_sys), .bus_strobe(bus_strobe), .reg_select(reg_select),
		.read_not_write(read_not_write), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
		.rd_valid(host_rv), .rd_data(host_rd));

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic cmp_byte(input logic [7:0] e, input logic [7:0] a);
		check_count++;
		if (a !== e) begin
			err_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : cmp_byte

	task automatic cmp_cols(input logic [99:0] e, input logic [99:0] a);
		check_count++;
		if (a !== e) begin
			err_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : cmp_cols

	// Oldest note is matched against each result as it appears
	always @(posedge clk_sys) begin
		if (host_rv || scan_v) begin
			cmp_byte(exp_q.pop_front(), host_rv ? host_rd : scan_cap);
		end
	end

	// A hang ends the run through the same report
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// Host and scan stimulus
	// ----------------------------------------------------------------
	task automatic cmd(input logic [7:0] c);
		logic [7:0] q;
		host.access(1'b0, 1'b0, c, 1'b0, q);
	endtask : cmd

	task automatic wr(input logic [7:0] c);
		logic [7:0] q;
		host.access(1'b1, 1'b0, c, 1'b0, q);
	endtask : wr

	task automatic rd(input logic rs, input logic [7:0] e);
		logic [7:0] q;
		exp_q.push_back(e);
		host.access(rs, 1'b1, 8'h00, 1'b1, q);
	endtask : rd

	// Host keeps off the command register until busy reads low; bounded poll
	task automatic wait_idle();
		logic [7:0] q;
		for (int i = 0; i < 20; i++) begin
			host.access(1'b0, 1'b1, 8'h00, 1'b0, q);
			if (q[7] === 1'b0) begin
				break;
			end
		end
	endtask : wait_idle

	task automatic cmd_w(input logic [7:0] c);
		cmd(c);
		wait_idle();
	endtask : cmd_w

	// Scan result is captured 1 ns after the second edge, one cycle after scan_char loads
	task automatic scan(input logic l, input logic [6:0] c, input logic [7:0] e);
		exp_q.push_back(e);
		scan_line = l;
		scan_col = c;
		repeat (2) @(posedge clk_sys);
		#1;
		scan_cap = scan_char;
		scan_v = 1'b1;
		@(posedge clk_sys);
		#1;
		scan_v = 1'b0;
	endtask : scan

	// Slave frame of 100 bits; clock stands low between frames
	task automatic frame(input logic dir, input logic [99:0] val);
		shift_direction = dir;
		for (int i = 0; i < 100; i++) begin
			casc_data_in = dir ? val[i] : val[99-i];
			casc_clk_in = 1'b1;
			repeat (3) @(posedge clk_sys);
			#1;
			casc_clk_in = 1'b0;
			repeat (3) @(posedge clk_sys);
			#1;
		end
		casc_data_in = ~casc_data_in;
		casc_latch_in = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		casc_latch_in = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		cmp_cols(val, casc_columns);
		// Serial out is the stage at the far end of the chosen direction
		cmp_byte({7'h00, (dir ? val[0] : val[99])}, {7'h00, casc_dout});
	endtask : frame

	initial begin
		scan_v = 1'b0;
		scan_cap = 8'h00;
		foreach (d[i]) d[i] = 8'($random(seed));
		repeat (16) @(posedge clk_sys);
		#1;
		srst = 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(1'b0, 8'h00);
		cmd(8'hFE);
		rd(1'b0, 8'hFE);
		cmd(8'h90);
		wait_idle();
		rd(1'b0, 8'h7E);
		for (int i = 0; i < 3; i++) wr(d[i]);
		wait_idle();
		rd(1'b0, 8'h01);
		cmd_w(8'hFE);
		for (int i = 0; i < 3; i++) begin
			rd(1'b1, d[i]);
			wait_idle();
		end
		cmd_w(8'h04);
		cmd_w(8'h80);
		wr(d[2]);
		wait_idle();
		rd(1'b0, 8'h7F);
		cmd_w(8'h06);
		cmd_w(8'h43);
		wr(d[3]);
		wait_idle();
		rd(1'b0, 8'h04);
		cmd_w(8'h43);
		rd(1'b1, d[3]);
		scan(1'b0, 7'h7E, d[0]);
		cmd_w(8'h1C);
		scan(1'b0, 7'h00, d[1]);
		scan(1'b0, 7'h01, d[2]);
		cmd_w(8'h18);
		cmd_w(8'hBF);
		wr(d[3]);
		wr(d[4]);
		wait_idle();
		cmd_w(8'h28);
		scan(1'b1, 7'h00, d[4]);
		cmd_w(8'h1C);
		scan(1'b0, 7'h00, d[3]);
		scan(1'b1, 7'h00, d[1]);
		scan(1'b1, 7'h01, d[4]);
		cmp_byte(8'h00, {7'h00, casc_oe});
		v = 100'({$random(seed), $random(seed), $random(seed), $random(seed)});
		frame(1'b1, v);
		frame(1'b0, ~v);
		role_master = 1'b1;
		seen = 1'b0;
		lat_seen = 1'b0;
		// Long enough for one whole master frame of 100 falls and its latch
		repeat (480) begin
			@(posedge clk_sys);
			#1;
			seen = seen | cascade_shift_clock;
			lat_seen = lat_seen | casc_lat;
		end
		cmp_byte(8'h03, {6'h00, lat_seen, casc_oe & seen});
		end_of_test();
	end
endmodule : cdh_host_port_tb_top
